// ---- hdl/alt_input_pkg.sv ----
// Constants, types and register map of the alternate data input block.
// Assumes a host register port on mclk and a test port clock from the link.
package alt_input_pkg;

  localparam int IR_WIDTH    = 8;
  localparam int DR_WIDTH    = 32;
  localparam int OUT_WIDTH   = 14;
  localparam int IN_WIDTH    = 4;
  localparam int ADDR_WIDTH  = 4;
  localparam int COUNT_WIDTH = 3;

  localparam logic [IR_WIDTH-1:0] OP_IDCODE = 8'h16;

  // Register indices
  localparam logic [ADDR_WIDTH-1:0] REG_CONTROL   = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] REG_STATUS    = 4'h1;
  localparam logic [ADDR_WIDTH-1:0] REG_SIGNATURE = 4'h2;
  localparam logic [ADDR_WIDTH-1:0] REG_CONFIG    = 4'h3;
  localparam logic [ADDR_WIDTH-1:0] REG_FUSE      = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] REG_REPROGRAM = 4'h5;

  // Field positions
  localparam int CTRL_OE_BIT   = 14;
  localparam int CTRL_HV_BIT   = 15;
  localparam int ST_ALT_BIT    = 0;
  localparam int ST_PROG_BIT   = 1;
  localparam int ST_FUSE_BIT   = 2;
  localparam int ST_IN_LSB     = 8;
  localparam int FUSE_SET_BIT  = 0;

  localparam logic [31:0] SIGNATURE_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] ZERO_WORD       = 32'h00000000;

  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE,
    SEL_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SEL_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_type;

  typedef struct packed {
    tap_state_type          state;
    logic [IR_WIDTH-1:0]    ir;
    logic [IR_WIDTH-1:0]    ir_shift;
    logic [DR_WIDTH-1:0]    dr_shift;
    logic [COUNT_WIDTH-1:0] id_count;
    logic                   alt_latch;
    logic                   use_alt;
    logic                   tdo;
    logic                   tdo_oe;
  } link_state_type;

  typedef struct packed {
    logic [31:0]          rdata;
    logic [15:0]          control;
    logic [31:0]          signature;
    logic [31:0]          config_word;
    logic                 fuse;
    logic [OUT_WIDTH-1:0] user_out;
    logic                 user_out_oe;
    logic                 hv_gate;
  } host_state_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_type;

endpackage

// ---- hdl/pin_sync.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous level input and an active-high async reset.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import alt_input_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b0
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);

  sync_state_type s;
  sync_state_type next_s;

  always_comb
  begin
    next_s    = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3)
    begin
      next_s.level = s.s3;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= {RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign level = s.level;

endmodule
`default_nettype wire

// ---- hdl/alt_input_select.sv ----
// Test access port with standard or alternate serial data input,
// plus signature, readout lock and programming-only supply handling.
// Assumes tck from the link host and a register port on mclk.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module alt_input_select
  import alt_input_pkg::*;
#(
  parameter logic [DR_WIDTH-1:0]    ID_VALUE        = 32'h0000A001,
  parameter logic [COUNT_WIDTH-1:0] ID_COUNT_TARGET = 3'h4
)(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [ADDR_WIDTH-1:0] addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [31:0]           rdata,
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  input  wire logic                  alternate_serial_data_in,
  input  wire logic                  alt_input_select_pin,
  output logic                       tdo,
  output logic                       tdo_oe,
  input  wire logic                  programming_only_supply,
  input  wire logic [IN_WIDTH-1:0]   user_in,
  output logic      [OUT_WIDTH-1:0]  user_out,
  output logic                       user_out_oe,
  output logic                       high_voltage_gate_output
);

  // Elaboration check
  generate
    if (ID_COUNT_TARGET < 3'h1)
    begin : bad_count
      $error("ID_COUNT_TARGET must be at least one");
    end
  endgenerate

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic is_idcode(input logic [IR_WIDTH-1:0] code);
    is_idcode = (code == OP_IDCODE);
  endfunction

  function automatic logic is_shift(input tap_state_type st);
    is_shift = (st == SHIFT_DR) || (st == SHIFT_IR);
  endfunction

  function automatic tap_state_type tap_next(input tap_state_type st,
                                             input logic          m);
    unique case (st)
      TEST_RESET: tap_next = m ? TEST_RESET : RUN_IDLE;
      RUN_IDLE:   tap_next = m ? SEL_DR     : RUN_IDLE;
      SEL_DR:     tap_next = m ? SEL_IR     : CAPTURE_DR;
      CAPTURE_DR: tap_next = m ? EXIT1_DR   : SHIFT_DR;
      SHIFT_DR:   tap_next = m ? EXIT1_DR   : SHIFT_DR;
      EXIT1_DR:   tap_next = m ? UPDATE_DR  : PAUSE_DR;
      PAUSE_DR:   tap_next = m ? EXIT2_DR   : PAUSE_DR;
      EXIT2_DR:   tap_next = m ? UPDATE_DR  : SHIFT_DR;
      UPDATE_DR:  tap_next = m ? SEL_DR     : RUN_IDLE;
      SEL_IR:     tap_next = m ? TEST_RESET : CAPTURE_IR;
      CAPTURE_IR: tap_next = m ? EXIT1_IR   : SHIFT_IR;
      SHIFT_IR:   tap_next = m ? EXIT1_IR   : SHIFT_IR;
      EXIT1_IR:   tap_next = m ? UPDATE_IR  : PAUSE_IR;
      PAUSE_IR:   tap_next = m ? EXIT2_IR   : PAUSE_IR;
      EXIT2_IR:   tap_next = m ? UPDATE_IR  : SHIFT_IR;
      UPDATE_IR:  tap_next = m ? SEL_DR     : RUN_IDLE;
    endcase
  endfunction

  // ****************************************
  // Synchronisers
  // ****************************************
  logic                select_level;
  logic                alt_level;
  logic                prog_level;
  logic [IN_WIDTH-1:0] in_level;

  // Pulled-up pin: reset value high keeps the standard input
  pin_sync #(.RESET_VALUE(1'b1)) select_sync (
    .clk   (tck),
    .rst   (rst),
    .pin   (alt_input_select_pin),
    .level (select_level)
  );

  link_state_type l;
  link_state_type next_l;

  pin_sync #(.RESET_VALUE(1'b0)) alt_sync (
    .clk   (mclk),
    .rst   (rst),
    .pin   (l.use_alt),
    .level (alt_level)
  );

  pin_sync #(.RESET_VALUE(1'b0)) prog_sync (
    .clk   (mclk),
    .rst   (rst),
    .pin   (programming_only_supply),
    .level (prog_level)
  );

  genvar gi;
  generate
    for (gi = 0; gi < IN_WIDTH; gi++)
    begin : in_sync
      pin_sync #(.RESET_VALUE(1'b0)) u_sync (
        .clk   (mclk),
        .rst   (rst),
        .pin   (user_in[gi]),
        .level (in_level[gi])
      );
    end
  endgenerate

  // ****************************************
  // Link domain: test access port
  // ****************************************
  logic din;

  always_comb
  begin
    din = l.use_alt ? alternate_serial_data_in : tdi;
  end

  always_comb
  begin
    next_l       = l;
    next_l.state = tap_next(l.state, tms);
    unique case (l.state)
      TEST_RESET:
      begin
        next_l.ir        = OP_IDCODE;
        next_l.id_count  = '0;
        next_l.alt_latch = 1'b0;
      end
      CAPTURE_IR:
      begin
        next_l.ir_shift = OP_IDCODE;
      end
      SHIFT_IR:
      begin
        next_l.ir_shift = {din, l.ir_shift[IR_WIDTH-1:1]};
      end
      UPDATE_IR:
      begin
        next_l.ir = l.ir_shift;
        if (is_idcode(l.ir_shift))
        begin
          if (l.id_count != ID_COUNT_TARGET)
          begin
            next_l.id_count = l.id_count + 3'h1;
          end
          if (select_level && (l.id_count == ID_COUNT_TARGET - 3'h1))
          begin
            next_l.alt_latch = 1'b1;
          end
        end
        else
        begin
          next_l.id_count = '0;
        end
      end
      CAPTURE_DR:
      begin
        if (is_idcode(l.ir))
        begin
          next_l.dr_shift = ID_VALUE;
        end
        else
        begin
          next_l.dr_shift = ZERO_WORD;
        end
      end
      SHIFT_DR:
      begin
        if (is_idcode(l.ir))
        begin
          next_l.dr_shift = {din, l.dr_shift[DR_WIDTH-1:1]};
        end
        else
        begin
          next_l.dr_shift = {l.dr_shift[DR_WIDTH-1:1], din};
        end
      end
      default:
      begin
      end
    endcase
    // Selection moves only outside a shift
    if (!is_shift(l.state))
    begin
      next_l.use_alt = !select_level || next_l.alt_latch;
    end
    next_l.tdo_oe = is_shift(next_l.state);
    next_l.tdo    = (next_l.state == SHIFT_IR) ? next_l.ir_shift[0]
                                               : next_l.dr_shift[0];
  end

  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
    begin
      l.state     <= TEST_RESET;
      l.ir        <= OP_IDCODE;
      l.ir_shift  <= '0;
      l.dr_shift  <= '0;
      l.id_count  <= '0;
      l.alt_latch <= 1'b0;
      l.use_alt   <= 1'b0;
      l.tdo       <= 1'b0;
      l.tdo_oe    <= 1'b0;
    end
    else
    begin
      l <= next_l;
    end
  end

  assign tdo    = l.tdo;
  assign tdo_oe = l.tdo_oe;

  // ****************************************
  // Host domain: registers and outputs
  // ****************************************
  host_state_type h;
  host_state_type next_h;

  always_comb
  begin
    next_h       = h;
    next_h.rdata = ZERO_WORD;
    if (rd)
    begin
      unique case (addr)
        REG_CONTROL:   next_h.rdata = {16'h0000, h.control};
        REG_STATUS:
        begin
          next_h.rdata[ST_ALT_BIT]  = alt_level;
          next_h.rdata[ST_PROG_BIT] = prog_level;
          next_h.rdata[ST_FUSE_BIT] = h.fuse;
          if (!prog_level)
          begin
            next_h.rdata[ST_IN_LSB +: IN_WIDTH] = in_level;
          end
        end
        REG_SIGNATURE: next_h.rdata = h.signature;
        REG_CONFIG:    next_h.rdata = h.fuse ? ZERO_WORD
                                             : h.config_word;
        default:       next_h.rdata = ZERO_WORD;
      endcase
    end
    if (wr)
    begin
      unique case (addr)
        REG_CONTROL:
        begin
          if (!prog_level)
          begin
            next_h.control = wdata[15:0];
          end
        end
        REG_SIGNATURE: next_h.signature = wdata;
        REG_FUSE:
        begin
          if (wdata[FUSE_SET_BIT])
          begin
            next_h.fuse = 1'b1;
          end
        end
        REG_REPROGRAM:
        begin
          next_h.config_word = wdata;
          next_h.fuse        = 1'b0;
        end
        default:
        begin
        end
      endcase
    end
    next_h.user_out    = h.control[OUT_WIDTH-1:0];
    next_h.user_out_oe = h.control[CTRL_OE_BIT] && !prog_level;
    next_h.hv_gate     = h.control[CTRL_HV_BIT] && !prog_level;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      h.rdata       <= ZERO_WORD;
      h.control     <= 16'h0000;
      h.signature   <= SIGNATURE_RESET;
      h.config_word <= ZERO_WORD;
      h.fuse        <= 1'b0;
      h.user_out    <= '0;
      h.user_out_oe <= 1'b0;
      h.hv_gate     <= 1'b0;
    end
    else
    begin
      h <= next_h;
    end
  end

  assign rdata                    = h.rdata;
  assign user_out                 = h.user_out;
  assign user_out_oe              = h.user_out_oe;
  assign high_voltage_gate_output = h.hv_gate;

  // ****************************************
  // Assertions
  // ****************************************
  select_low_alt_a: assert property (
    @(posedge tck) disable iff (rst)
    (!select_level && !is_shift(l.state)) |=> l.use_alt)
    else $error("low select did not choose alternate input");

  select_high_std_a: assert property (
    @(posedge tck) disable iff (rst)
    (select_level && !next_l.alt_latch && !is_shift(l.state))
      |=> !l.use_alt)
    else $error("high select did not keep standard input");

  fourth_id_a: assert property (
    @(posedge tck) disable iff (rst)
    (l.state == UPDATE_IR && is_idcode(l.ir_shift) && select_level
      && l.id_count == ID_COUNT_TARGET - 3'h1) |=> l.alt_latch)
    else $error("identification sequence did not latch alternate");

  latch_held_a: assert property (
    @(posedge tck) disable iff (rst)
    (l.alt_latch && l.state != TEST_RESET) |=> l.alt_latch)
    else $error("alternate selection lost outside reset state");

  reset_clears_a: assert property (
    @(posedge tck) disable iff (rst)
    (l.state == TEST_RESET) |=> (l.ir == OP_IDCODE && !l.alt_latch
      && l.id_count == '0))
    else $error("reset state did not restore instruction and selection");

  tms_five_a: assert property (
    @(posedge tck) disable iff (rst)
    tms [*5] |=> (l.state == TEST_RESET))
    else $error("five high mode clocks did not reach reset state");

  other_instr_a: assert property (
    @(posedge tck) disable iff (rst)
    (l.state == UPDATE_IR && !is_idcode(l.ir_shift)) |=> l.id_count == '0)
    else $error("counter not restarted by other instruction");

  shift_stable_a: assert property (
    @(posedge tck) disable iff (rst)
    is_shift(l.state) |=> $stable(l.use_alt))
    else $error("input selection changed during a shift");

  id_capture_a: assert property (
    @(posedge tck) disable iff (rst)
    (l.state == CAPTURE_DR && is_idcode(l.ir)) |=> l.dr_shift == ID_VALUE)
    else $error("identification register not captured");

  prog_quiet_a: assert property (
    @(posedge mclk) disable iff (rst)
    prog_level |=> (!user_out_oe && !high_voltage_gate_output))
    else $error("outputs active in programming-only supply");

  lock_read_a: assert property (
    @(posedge mclk) disable iff (rst)
    (rd && addr == REG_CONFIG && h.fuse) |=> rdata == ZERO_WORD)
    else $error("locked configuration was read out");

  fuse_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    (h.fuse && !(wr && addr == REG_REPROGRAM)) |=> h.fuse)
    else $error("fuse cleared without reprogramming");

  signature_a: assert property (
    @(posedge mclk) disable iff (rst)
    (rd && addr == REG_SIGNATURE) |=> rdata == $past(h.signature))
    else $error("signature word not returned");

endmodule
`default_nettype wire

// ---- sim/jtag_host.sv ----
// Behavioural test port host: drives clock, mode and both data lines.
// Assumes the device samples mode and data on the rising test clock.
`timescale 1ns/1ps
`default_nettype none
module jtag_host
(
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      alternate_serial_data_in,
  input  wire logic tdo
);
  localparam realtime HALF = 62.5;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    alternate_serial_data_in = 1'b1;
  end

  // ****************************************
  // Frame tasks; clock stands still between
  // ****************************************
  task automatic step(input logic m);
    tms = m;
    #HALF tck = 1'b1;
    #HALF tck = 1'b0;
  endtask

  task automatic shift(input logic [63:0] din, input int n,
                       input logic on_alt, output logic [63:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      dout[i] = tdo;
      tdi = on_alt ? ~din[i] : din[i];
      alternate_serial_data_in = on_alt ? din[i] : ~din[i];
      step(i == n - 1);
    end
    // Released lines show the inverse of their last value
    tdi = ~tdi;
    alternate_serial_data_in = ~alternate_serial_data_in;
  endtask

  task automatic reset_tap();
    repeat (5) step(1'b1);
    step(1'b0);
  endtask

  task automatic scan_ir(input logic [7:0] op, input logic on_alt);
    logic [63:0] unused;
    step(1'b1);
    step(1'b1);
    step(1'b0);
    step(1'b0);
    shift({56'h0, op}, 8, on_alt, unused);
    step(1'b1);
    step(1'b0);
  endtask

  task automatic scan_dr(input logic [63:0] din, input logic on_alt,
                         output logic [63:0] dout);
    step(1'b1);
    step(1'b0);
    step(1'b0);
    shift(din, 64, on_alt, dout);
    step(1'b1);
    step(1'b0);
  endtask
endmodule
`default_nettype wire

// ---- sim/alt_input_select_test.sv ----
// Self-checking bench for the alternate data input block.
// Assumes the host model in jtag_host.sv and the design package.
`timescale 1ns/1ps
`default_nettype none
module alt_input_select_test
  import alt_input_pkg::*;
;
  localparam logic [31:0] ID_VAL  = 32'h5A3C0F11; // Arbitrary value
  localparam logic [31:0] PATTERN = 32'hC3A51E69;

  logic                  mclk = 1'b0;
  logic                  rst = 1'b1;
  logic [ADDR_WIDTH-1:0] addr = '0;
  logic [31:0]           wdata = '0;
  logic                  wr = 1'b0;
  logic                  rd = 1'b0;
  logic [31:0]           rdata;
  logic                  tck;
  logic                  tms;
  logic                  tdi;
  logic                  alt_tdi;
  logic                  tdo;
  logic                  sel_en = 1'b1;
  logic                  sel_val = 1'b1;
  tri1                   sel_pin;
  logic                  prog_only = 1'b0;
  logic [IN_WIDTH-1:0]   user_in = 4'hA;
  logic [OUT_WIDTH-1:0]  user_out;
  logic                  user_out_oe;
  logic                  hv_out;
  logic                  tdo_oe;
  int                    n_mismatch = 0;
  int                    num_checks = 0;

  assign sel_pin = sel_en ? sel_val : 1'bz;

  always #25 mclk = ~mclk;

  alt_input_select #(.ID_VALUE(ID_VAL)) uut
  (
    .mclk                     (mclk),
    .rst                      (rst),
    .addr                     (addr),
    .wdata                    (wdata),
    .wr                       (wr),
    .rd                       (rd),
    .rdata                    (rdata),
    .tck                      (tck),
    .tms                      (tms),
    .tdi                      (tdi),
    .alternate_serial_data_in (alt_tdi),
    .alt_input_select_pin     (sel_pin),
    .tdo                      (tdo),
    .tdo_oe                   (tdo_oe),
    .programming_only_supply  (prog_only),
    .user_in                  (user_in),
    .user_out                 (user_out),
    .user_out_oe              (user_out_oe),
    .high_voltage_gate_output (hv_out)
  );

  jtag_host host
  (
    .tck                      (tck),
    .tms                      (tms),
    .tdi                      (tdi),
    .alternate_serial_data_in (alt_tdi),
    .tdo                      (tdo)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want,
                       input string what);
    num_checks++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h want %h",
               $time, what, seen, want);
    end
  endtask

  task automatic bus_write(input logic [ADDR_WIDTH-1:0] a,
                           input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [ADDR_WIDTH-1:0] a,
                          output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic read_check(input logic [ADDR_WIDTH-1:0] a,
                            input logic [31:0] mask, input logic [31:0] want);
    logic [31:0] d;
    repeat (8) @(posedge mclk);
    bus_read(a, d);
    check(d & mask, want, "register read");
  endtask

  task automatic probe(input logic on_alt);
    logic [63:0] seen;
    host.scan_dr({~PATTERN, PATTERN}, on_alt, seen);
    check(seen[31:0], ID_VAL, "identification word");
    check(seen[63:32], PATTERN, "data input choice");
  endtask

  task automatic set_pin(input logic en, input logic v);
    @(posedge mclk);
    sel_en <= en;
    sel_val <= v;
    @(posedge mclk);
    host.reset_tap();
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    #1 check({user_out_oe, hv_out, tdo_oe, user_out}, '0, "reset outputs");
    read_check(REG_SIGNATURE, '1, SIGNATURE_RESET);
    read_check(4'hF, '1, ZERO_WORD);
    $display("reset test done");
  endtask

  task automatic t_registers();
    bus_write(REG_CONTROL, 32'h0000C001);
    repeat (2) @(posedge mclk);
    #1 check({user_out_oe, hv_out, user_out}, 32'hC001, "control");
    bus_write(REG_SIGNATURE, 32'h13579BDF);
    read_check(REG_SIGNATURE, '1, 32'h13579BDF);
    bus_write(REG_REPROGRAM, 32'h1234ABCD);
    bus_write(REG_FUSE, 32'h0);
    read_check(REG_CONFIG, '1, 32'h1234ABCD);
    bus_write(REG_FUSE, 32'h1);
    read_check(REG_CONFIG, '1, ZERO_WORD);
    read_check(REG_STATUS, 32'h4, 32'h4);
    bus_write(REG_REPROGRAM, 32'h00000055);
    read_check(REG_CONFIG, '1, 32'h55);
    read_check(REG_STATUS, 32'h4, 32'h0);
    $display("register test done");
  endtask

  task automatic t_prog_only();
    @(posedge mclk);
    prog_only <= 1'b1;
    repeat (8) @(posedge mclk);
    #1 check({user_out_oe, hv_out}, 32'h0, "outputs released");
    read_check(REG_STATUS, 32'hF07, 32'h002);
    bus_write(REG_CONTROL, 32'h0);
    @(posedge mclk);
    prog_only <= 1'b0;
    read_check(REG_STATUS, 32'hF07, 32'hA00);
    #1 check({user_out_oe, hv_out}, 32'h3, "control kept");
    $display("programming supply test done");
  endtask

  task automatic t_select_pin();
    set_pin(1'b1, 1'b0);
    probe(1'b1);
    read_check(REG_STATUS, 32'h1, 32'h1);
    set_pin(1'b1, 1'b1);
    probe(1'b0);
    set_pin(1'b0, 1'b0);
    probe(1'b0);
    $display("select pin test done");
  endtask

  task automatic t_id_count();
    set_pin(1'b1, 1'b1);
    repeat (3) host.scan_ir(OP_IDCODE, 1'b0);
    host.scan_ir(8'hFF, 1'b0);
    repeat (3) host.scan_ir(OP_IDCODE, 1'b0);
    probe(1'b0);
    host.scan_ir(OP_IDCODE, 1'b0);
    probe(1'b1);
    probe(1'b1);
    read_check(REG_STATUS, 32'h1, 32'h1);
    host.reset_tap();
    probe(1'b0);
    read_check(REG_STATUS, 32'h1, 32'h0);
    $display("instruction count test done");
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_registers();
    t_prog_only();
    t_select_pin();
    t_id_count();
    tally_and_finish();
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
